// ===== dv/qpot_link_monitor.sv
// concurrent checks on the two-wire link between the pot master and slave
`default_nettype none
module qpot_link_monitor #(
    parameter int PROG_CYCLES = 2000
)(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic scl_oe,
    input wire logic sda_s_oe,
    input wire logic scl,
    input wire logic sda,
    input wire logic prog_busy
);
    int unsigned busy_cnt_r;

    // length of the running program cycle, cleared when it ends
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_cnt_r <= 0;
        end else if (prog_busy) begin
            busy_cnt_r <= busy_cnt_r + 1;
        end else begin
            busy_cnt_r <= 0;
        end
    end

    default clocking mon_cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_busy_silent: assert property (prog_busy |-> !sda_s_oe)
        else $error("slave pulls sda while programming");
    chk_sda_steady: assert property (scl && $past(scl) |-> $stable(sda_s_oe))
        else $error("slave sda moved while scl high");
    chk_ack_hold: assert property ($rose(sda_s_oe) |=> sda_s_oe [*8])
        else $error("slave pull too short");
    chk_read_release: assert property ($fell(sda_s_oe) |-> !scl)
        else $error("slave released sda with scl high");
    chk_busy_bound: assert property (busy_cnt_r <= PROG_CYCLES)
        else $error("program cycle too long");
    chk_busy_at_stop: assert property ($rose(prog_busy) |-> scl && sda)
        else $error("program cycle began outside a stop");
    chk_scl_high_min: assert property ($fell(scl_oe) |-> !scl_oe [*8])
        else $error("scl high phase too short");
    chk_start_clock: assert property (scl && $past(scl) && $fell(sda) |-> ##[1:100] !scl)
        else $error("no clock after start");
    chk_stop_idle: assert property (scl && $past(scl) && $rose(sda) |=> (scl && sda && !sda_s_oe) [*4])
        else $error("bus not idle after stop");
endmodule
`default_nettype wire

// ===== dv/qpot_tb_top.sv
// self-checking bench: ahb master and pot slave joined over the link
`include "qpot_defines.svh"
`default_nettype none
module qpot_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int PROG = 2000;
    localparam int PWRUP = 100;
    localparam logic [7:0] ADR = {`QPOT_TYPE_ID, 4'ha};
    localparam logic [31:0] BAD_OPS = 32'hf7654320;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, prog_busy, scl_d;
    logic [1:0]  htrans;
    logic [2:0]  hsize, ak;
    logic [3:0]  addr_pin;
    logic [9:0]  cap;
    logic [23:0] wiper_out;
    logic [31:0] haddr, hwdata, hrdata, q;
    int          num_errors, check_count;

    qpot_if link ();
    // open-drain wires: any enabled party pulls low
    assign link.scl = !link.scl_oe;
    assign link.sda = !(link.sda_m_oe | link.sda_s_oe);

    qpot_master u_qpot_master (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .bus(link.master));
    qpot_slave #(.PROG_CYCLES(PROG), .PWRUP_CYCLES(PWRUP)) u_qpot_slave (.hclk(hclk), .hresetn(hresetn),
        .addr_pin(addr_pin), .wiper_out(wiper_out), .prog_busy(prog_busy), .bus(link.slave));
    qpot_link_monitor #(.PROG_CYCLES(PROG)) u_qpot_link_monitor (.hclk(hclk), .hresetn(hresetn),
        .scl_oe(link.scl_oe), .sda_s_oe(link.sda_s_oe), .scl(link.scl), .sda(link.sda), .prog_busy(prog_busy));

    always #2 hclk = ~hclk;

    // sda as seen at each scl rise, incl. the one before a stop
    always @(posedge hclk) begin
        scl_d <= link.scl;
        if (link.scl && !scl_d) begin
            cap <= {cap[8:0], link.sda};
        end
    end

    task automatic chk_bit(input logic got, input logic exp, input string what);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: %s got %b want %b", $time, what, got, exp);
        end
    endtask

    task automatic chk_vec(input logic [23:0] got, input logic [23:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        q = hrdata;
    endtask

    // one byte per command; waits for busy to rise, then to fall
    task automatic send_byte(input logic [7:0] b, input logic [2:0] cmd, output logic ack);
        logic [31:0] st;
        int n;
        ahb(1'h1, `QPOT_OFF_DATA, {24'h0, b}, st);
        ahb(1'h1, `QPOT_OFF_CMD, {29'h0, cmd}, st);
        for (int p = 1; p >= 0; p--) begin
            n = 0;
            do begin
                ahb(1'h0, `QPOT_OFF_STATUS, 32'h0, st);
                n++;
            end while (st[0] !== p[0] && n < 500);
        end
        ack = st[1];
    endtask

    // n bytes: address, instruction, data; stop after the last, nack it on a read
    task automatic xfer(input logic [7:0] ab, input logic [7:0] ib, input logic [7:0] db, input int n,
                        input logic rd, output logic [2:0] a);
        a = 3'h0;
        send_byte(ab, (n == 1) ? 3'h3 : 3'h1, a[0]);
        if (n > 1) send_byte(ib, (n == 2) ? 3'h2 : 3'h0, a[1]);
        if (n > 2) send_byte(rd ? 8'hff : db, 3'h2, a[2]);
        repeat (4) @(posedge hclk); // the slave sees the stop a few cycles late
    endtask

    task automatic wait_prog();
        int n;
        n = 0;
        while (prog_busy !== 1'h0 && n < PROG) begin
            @(posedge hclk);
            n++;
        end
        chk_bit(prog_busy, 1'h0, "program end");
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // reckoned at about two and a half times the expected run length
    initial begin
        repeat (90000) @(posedge hclk);
        num_errors++;
        $display("MISMATCH at %0t: run did not finish", $time);
        end_sim();
    end

    initial begin
        hclk = 1'h0;
        hresetn = 1'h0;
        hsel = 1'h1;
        hsize = 3'h2;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'h0;
        hwdata = 32'h0;
        addr_pin = 4'ha;
        num_errors = 0;
        check_count = 0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'h1;
        repeat (PWRUP) @(posedge hclk);
        chk_vec(wiper_out, {4{6'h20}}, "power-up wipers");
        chk_bit(link.scl & link.sda, 1'h1, "idle lines");
        xfer(ADR, 8'ha4, 8'h15, 3, 1'h0, ak);
        chk_vec({21'h0, ak}, 24'h7, "write acks");
        chk_vec({14'h0, cap}, {14'h0, 8'h15, 2'h0}, "data byte on wire");
        chk_vec(wiper_out, {6'h20, 6'h20, 6'h15, 6'h20}, "wiper write");
        xfer({`QPOT_TYPE_ID, 4'h5}, 8'ha4, 8'h3f, 3, 1'h0, ak);
        chk_vec({21'h0, ak}, 24'h0, "foreign address acks");
        chk_vec({14'h0, cap}, {14'h0, 8'h3f, 2'h2}, "nack on wire");
        chk_vec(wiper_out, {6'h20, 6'h20, 6'h15, 6'h20}, "foreign address");
        xfer(ADR, 8'hcb, 8'h2a, 3, 1'h0, ak);
        chk_bit(prog_busy, 1'h1, "program cycle");
        xfer(ADR, 8'h00, 8'h00, 1, 1'h0, ak);
        chk_bit(ak[0], 1'h0, "poll while busy");
        chk_vec({14'h0, cap}, {14'h0, ADR, 2'h2}, "poll on wire");
        wait_prog();
        xfer(ADR, 8'h00, 8'h00, 1, 1'h0, ak);
        chk_bit(ak[0], 1'h1, "poll after program");
        chk_vec({14'h0, cap}, {14'h0, ADR, 2'h0}, "address on wire");
        xfer(ADR, 8'hdb, 8'h00, 2, 1'h0, ak);
        chk_vec(wiper_out, {6'h20, 6'h2a, 6'h15, 6'h20}, "setting three to wiper");
        xfer(ADR, 8'he5, 8'h00, 2, 1'h0, ak);
        wait_prog();
        xfer(ADR, 8'ha4, 8'h07, 3, 1'h0, ak);
        chk_vec(wiper_out, {6'h20, 6'h2a, 6'h07, 6'h20}, "wiper rewrite");
        xfer(ADR, 8'hd5, 8'h00, 2, 1'h0, ak);
        chk_vec(wiper_out, {6'h20, 6'h2a, 6'h15, 6'h20}, "setting one back");
        xfer(ADR, 8'h82, 8'h00, 2, 1'h0, ak);
        wait_prog();
        xfer(ADR, 8'ha0, 8'h01, 3, 1'h0, ak);
        xfer(ADR, 8'h12, 8'h00, 2, 1'h0, ak);
        chk_vec(wiper_out, {6'h20, 6'h2a, 6'h15, 6'h20}, "global setting two");
        xfer(ADR, 8'h13, 8'h00, 2, 1'h0, ak);
        chk_vec(wiper_out, {6'h20, 6'h2a, 6'h20, 6'h20}, "global setting three");
        // inc/dec and the other seven undecoded opcodes are accepted but move nothing in this design
        for (int i = 0; i < 8; i++) begin
            xfer(ADR, {BAD_OPS[4*i +: 4], 4'h4}, 8'h01, 3, 1'h0, ak);
            chk_vec(wiper_out, {6'h20, 6'h2a, 6'h20, 6'h20}, "undefined opcode");
        end
        for (int r = 0; r < 2; r++) begin
            xfer(ADR, r ? 8'hb6 : 8'h98, 8'hff, 3, 1'h1, ak);
            chk_vec({22'h0, ak[1:0]}, 24'h3, "read acks");
            chk_bit(cap[1], 1'h1, "sda free on ninth read clock");
            ahb(1'h0, `QPOT_OFF_RDATA, 32'h0, q);
            chk_vec(q[23:0], r ? 24'h15 : 24'h2a, "read data");
        end
        // master acks the first read byte, so the slave must send a second one
        send_byte(ADR, 3'h1, ak[0]);
        send_byte(8'h98, 3'h0, ak[1]);
        send_byte(8'hff, 3'h4, ak[2]);
        send_byte(8'hff, 3'h2, ak[2]);
        chk_vec({22'h0, ak[1:0]}, 24'h3, "read after ack acks");
        ahb(1'h0, `QPOT_OFF_RDATA, 32'h0, q);
        chk_vec(q[23:0], 24'h2a, "read after ack");
        end_sim();
    end
endmodule
`default_nettype wire

// ===== hw/qpot_master.sv
// ahb-lite controlled two-wire master for the quad pot
`include "qpot_defines.svh"
`default_nettype none
module qpot_master
    import qpot_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    qpot_if.master           bus
);
    qpot_mst_state_type st_r;
    logic        ap_wr_r, ap_rd_r;
    logic [31:0] ap_addr_r;
    logic [7:0]  tx_r, rx_r, byte_r;
    logic        start_r, stop_r, rdack_r, ack_r, busy_r;
    logic [4:0]  div_r;
    logic        ph_r;
    logic [3:0]  bit_r;
    logic        s1_r, s2_r;
    logic        sda_drv_r, scl_low_r;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign bus.scl_o  = 1'b0;
    assign bus.scl_oe = scl_low_r;
    assign bus.sda_m_o  = 1'b0;
    assign bus.sda_m_oe = sda_drv_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_wr_r <= 1'b0;
            ap_rd_r <= 1'b0;
            ap_addr_r <= 32'h00000000;
        end else begin
            ap_wr_r <= hsel && hready && htrans[1] && hwrite;
            ap_rd_r <= hsel && hready && htrans[1] && !hwrite;
            ap_addr_r <= haddr;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) hrdata <= 32'h00000000;
        else if (hsel && hready && htrans[1] && !hwrite) begin
            unique case (haddr)
                `QPOT_OFF_STATUS: hrdata <= {30'h0, ack_r, busy_r};
                `QPOT_OFF_RDATA:  hrdata <= {24'h0, byte_r};
                default:          hrdata <= 32'h00000000;
            endcase
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_r <= 1'b1;
            s2_r <= 1'b1;
        end else begin
            s1_r <= bus.sda;
            s2_r <= s1_r;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= QPOT_M_IDLE;
            tx_r <= 8'h00;
            rx_r <= 8'h00;
            byte_r <= 8'h00;
            start_r <= 1'b0;
            stop_r <= 1'b0;
            rdack_r <= 1'b0;
            ack_r <= 1'b0;
            busy_r <= 1'b0;
            div_r <= 5'h00;
            ph_r <= 1'b0;
            bit_r <= 4'h0;
            sda_drv_r <= 1'b0;
            scl_low_r <= 1'b0;
        end else begin
            div_r <= (div_r == `QPOT_SCL_HALF) ? 5'h00 : div_r + 5'h01;
            if (ap_wr_r && ap_addr_r == `QPOT_OFF_DATA && !busy_r) tx_r <= hwdata[7:0];
            if (ap_wr_r && ap_addr_r == `QPOT_OFF_CMD && !busy_r) begin
                start_r <= hwdata[0];
                stop_r <= hwdata[1];
                rdack_r <= hwdata[2];
                busy_r <= 1'b1;
                st_r <= hwdata[0] ? QPOT_M_START : QPOT_M_BIT;
                bit_r <= 4'h0;
                ph_r <= 1'b0;
            end else if (div_r == `QPOT_SCL_HALF) begin
                unique case (st_r)
                    QPOT_M_IDLE: ;
                    QPOT_M_START: begin
                        if (!ph_r) begin
                            scl_low_r <= 1'b0;
                            sda_drv_r <= 1'b0;
                            ph_r <= 1'b1;
                        end else if (!sda_drv_r) sda_drv_r <= 1'b1;
                        else begin
                            scl_low_r <= 1'b1;
                            ph_r <= 1'b0;
                            st_r <= QPOT_M_BIT;
                        end
                    end
                    QPOT_M_BIT: begin
                        if (!ph_r) begin
                            scl_low_r <= 1'b1;
                            if (bit_r < 4'h8) sda_drv_r <= !tx_r[3'h7 - bit_r[2:0]];
                            else sda_drv_r <= rdack_r;
                            ph_r <= 1'b1;
                        end else begin
                            scl_low_r <= 1'b0;
                            ph_r <= 1'b0;
                            if (bit_r < 4'h8) rx_r <= {rx_r[6:0], s2_r};
                            else ack_r <= !s2_r;
                            if (bit_r == 4'h8) begin
                                byte_r <= rx_r;
                                st_r <= stop_r ? QPOT_M_STOP : QPOT_M_DONE;
                            end
                            bit_r <= bit_r + 4'h1;
                        end
                    end
                    QPOT_M_STOP: begin
                        if (!ph_r) begin
                            scl_low_r <= 1'b1;
                            sda_drv_r <= 1'b1;
                            ph_r <= 1'b1;
                        end else if (scl_low_r) scl_low_r <= 1'b0;
                        else begin
                            sda_drv_r <= 1'b0;
                            st_r <= QPOT_M_IDLE;
                            busy_r <= 1'b0;
                        end
                    end
                    QPOT_M_DONE: begin
                        scl_low_r <= 1'b1;
                        sda_drv_r <= 1'b0;
                        st_r <= QPOT_M_IDLE;
                        busy_r <= 1'b0;
                    end
                    default: st_r <= QPOT_M_IDLE;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ===== hw/qpot_slave.sv
// quad pot serial command slave with wiper and setting registers
`include "qpot_defines.svh"
`default_nettype none
// Operation
// - master waits 1 ms after power-up
// - program cycle ends within 5 ms
// - busy: interface off, sda released
// - master starts only on idle bus
// - sda change with scl high is start/stop
// - start is sda fall, scl high
// - stop is sda rise; operations end with stop
// - master clocks; device never drives scl
// - address: type id high, pins low
// - acknowledge only when pins match
// - receiver pulls sda low on ninth clock
// - write mode acknowledges every byte
// - read: send, release, continue on ack
// - write: start, address, instruction, data, stop
// - setting write stop starts program cycle
// - address polling acked once not busy
// - instruction: opcode, pot, setting fields
// - setting select bits are binary index
// - power-up loads wiper from setting zero
// - opcode decode of nine instructions (eight decoded here; inc/dec does nothing)
module qpot_slave
    import qpot_pkg::*;
#(
    parameter int PROG_CYCLES  = `QPOT_PROG_CYCLES,
    parameter int PWRUP_CYCLES = `QPOT_PWRUP_CYCLES,
    parameter logic [3:0] TYPE_ID = `QPOT_TYPE_ID // arbitrary value
)(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic [3:0]  addr_pin,
    output logic      [23:0] wiper_out,
    output logic             prog_busy,
    qpot_if.slave            bus
);
    initial begin
        if (PROG_CYCLES < 1 || PWRUP_CYCLES < 1) $error("cycle counts must be positive");
    end
    function automatic logic [3:0] idx(input logic [1:0] pot, input logic [1:0] set);
        idx = {pot, set};
    endfunction
    qpot_slv_state_type st_r;
    logic [5:0]  wiper_position_reg [4];
    logic [5:0]  stored_setting_reg [16];
    logic        c1_r, c2_r, d1_r, d2_r, c3_r, d3_r;
    logic [3:0]  ap1_r, ap2_r;
    logic [7:0]  sh_r, instr_r;
    logic [3:0]  cnt_r;
    logic [1:0]  nbyte_r;
    logic        rd_r, pend_r, sda_oe_r, loaded_r;
    logic [31:0] prog_r;
    logic        scl_rise, scl_fall, start_ev, stop_ev;
    assign bus.sda_s_o  = 1'b0;
    assign bus.sda_s_oe = sda_oe_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {c1_r, c2_r, c3_r, d1_r, d2_r, d3_r} <= 6'h3f;
            ap1_r <= 4'h0;
            ap2_r <= 4'h0;
        end else begin
            c1_r <= bus.scl;
            c2_r <= c1_r;
            c3_r <= c2_r;
            d1_r <= bus.sda;
            d2_r <= d1_r;
            d3_r <= d2_r;
            ap1_r <= addr_pin;
            ap2_r <= ap1_r;
        end
    end
    assign scl_rise = c2_r && !c3_r;
    assign scl_fall = !c2_r && c3_r;
    assign start_ev = c2_r && c3_r && d3_r && !d2_r;
    assign stop_ev  = c2_r && c3_r && !d3_r && d2_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prog_r <= 32'h0;
            prog_busy <= 1'b0;
        end else if (stop_ev && pend_r && prog_r == 32'h0) begin
            prog_r <= 32'(PROG_CYCLES);
            prog_busy <= 1'b1;
        end else if (prog_r != 32'h0) begin
            prog_r <= prog_r - 32'h1;
            prog_busy <= (prog_r != 32'h1);
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= QPOT_S_IDLE;
            sh_r <= 8'h00;
            instr_r <= 8'h00;
            cnt_r <= 4'h0;
            nbyte_r <= 2'h0;
            rd_r <= 1'b0;
            pend_r <= 1'b0;
            sda_oe_r <= 1'b0;
            loaded_r <= 1'b0;
            wiper_out <= 24'h0;
            for (int i = 0; i < 16; i++) stored_setting_reg[i] <= `QPOT_SETTING_RESET;
            for (int i = 0; i < 4; i++) wiper_position_reg[i] <= 6'h00;
        end else begin
            wiper_out <= {wiper_position_reg[3], wiper_position_reg[2], wiper_position_reg[1], wiper_position_reg[0]};
            if (!loaded_r) begin
                for (int i = 0; i < 4; i++)
                    wiper_position_reg[i] <= stored_setting_reg[idx(2'(i), 2'h0)];
                loaded_r <= 1'b1;
            end
            if (prog_busy || stop_ev) begin
                st_r <= QPOT_S_IDLE;
                sda_oe_r <= 1'b0;
                if (stop_ev) pend_r <= 1'b0;
            end else if (start_ev) begin
                st_r <= QPOT_S_RX;
                cnt_r <= 4'h0;
                nbyte_r <= 2'h0;
                sda_oe_r <= 1'b0;
            end else begin
                unique case (st_r)
                    QPOT_S_IDLE, QPOT_S_WAIT: ;
                    QPOT_S_RX: begin
                        if (scl_rise) begin
                            sh_r <= {sh_r[6:0], d2_r};
                            cnt_r <= cnt_r + 4'h1;
                        end else if (scl_fall && cnt_r == 4'h8) begin
                            cnt_r <= 4'h0;
                            if (nbyte_r == 2'h0) begin
                                if (sh_r[7:4] == TYPE_ID && sh_r[3:0] == ap2_r) begin
                                    rd_r <= 1'b0; // address byte carries no direction bit
                                    sda_oe_r <= 1'b1;
                                    st_r <= QPOT_S_ACK;
                                end else st_r <= QPOT_S_IDLE;
                            end else begin
                                sda_oe_r <= 1'b1;
                                st_r <= QPOT_S_ACK;
                                if (nbyte_r == 2'h1) begin
                                    instr_r <= sh_r;
                                    rd_r <= sh_r[7:4] == `QPOT_OP_RD_WIPER || sh_r[7:4] == `QPOT_OP_RD_SET;
                                    unique case (sh_r[7:4])
                                        `QPOT_OP_SET2WIPER:
                                            wiper_position_reg[sh_r[3:2]] <= stored_setting_reg[idx(sh_r[3:2], sh_r[1:0])];
                                        `QPOT_OP_WIPER2SET: begin
                                            stored_setting_reg[idx(sh_r[3:2], sh_r[1:0])] <= wiper_position_reg[sh_r[3:2]];
                                            pend_r <= 1'b1;
                                        end
                                        `QPOT_OP_GSET2WIPER:
                                            for (int i = 0; i < 4; i++)
                                                wiper_position_reg[i] <= stored_setting_reg[idx(2'(i), sh_r[1:0])];
                                        `QPOT_OP_GWIPER2SET: begin
                                            for (int i = 0; i < 4; i++)
                                                stored_setting_reg[idx(2'(i), sh_r[1:0])] <= wiper_position_reg[i];
                                            pend_r <= 1'b1;
                                        end
                                        default: ;
                                    endcase
                                end else if (nbyte_r == 2'h2) begin
                                    unique case (instr_r[7:4])
                                        `QPOT_OP_WR_WIPER: wiper_position_reg[instr_r[3:2]] <= sh_r[5:0];
                                        `QPOT_OP_WR_SET: begin
                                            stored_setting_reg[idx(instr_r[3:2], instr_r[1:0])] <= sh_r[5:0];
                                            pend_r <= 1'b1;
                                        end
                                        default: ;
                                    endcase
                                end
                            end
                            if (nbyte_r != 2'h3) nbyte_r <= nbyte_r + 2'h1;
                        end
                    end
                    QPOT_S_ACK: if (scl_fall) begin
                        if (rd_r) begin
                            sh_r <= instr_r[5] ? {2'h0, stored_setting_reg[idx(instr_r[3:2], instr_r[1:0])]}
                                               : {2'h0, wiper_position_reg[instr_r[3:2]]};
                            sda_oe_r <= 1'b1; // msb of a 6-bit value is always zero
                            cnt_r <= 4'h1;
                            st_r <= QPOT_S_TX;
                        end else begin
                            sda_oe_r <= 1'b0;
                            st_r <= QPOT_S_RX;
                        end
                    end
                    QPOT_S_TX: if (scl_fall) begin
                        if (cnt_r == 4'h8) begin
                            sda_oe_r <= 1'b0;
                            st_r <= QPOT_S_TACK;
                        end else begin
                            sda_oe_r <= !sh_r[3'h7 - cnt_r[2:0]];
                            cnt_r <= cnt_r + 4'h1;
                        end
                    end
                    QPOT_S_TACK: if (scl_rise) begin
                        if (!d2_r) begin
                            cnt_r <= 4'h0;
                            st_r <= QPOT_S_ACK;
                        end else st_r <= QPOT_S_WAIT;
                    end
                    default: st_r <= QPOT_S_IDLE;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ===== include/qpot_defines.svh
// constants for the quad pot serial command slave and its master
`ifndef QPOT_DEFINES_SVH
`define QPOT_DEFINES_SVH
`define QPOT_CLK_MHZ        250
`define QPOT_PROG_TIME_US   5000
`define QPOT_PROG_CYCLES    (`QPOT_PROG_TIME_US * `QPOT_CLK_MHZ)
`define QPOT_PWRUP_TIME_US  1000
`define QPOT_PWRUP_CYCLES   (`QPOT_PWRUP_TIME_US * `QPOT_CLK_MHZ)
`define QPOT_TYPE_ID        4'h0
`define QPOT_OP_RD_WIPER    4'h9
`define QPOT_OP_WR_WIPER    4'ha
`define QPOT_OP_RD_SET      4'hb
`define QPOT_OP_WR_SET      4'hc
`define QPOT_OP_SET2WIPER   4'hd
`define QPOT_OP_WIPER2SET   4'he
`define QPOT_OP_GSET2WIPER  4'h1
`define QPOT_OP_GWIPER2SET  4'h8
`define QPOT_OP_INCDEC      4'h2
`define QPOT_OFF_CMD        32'h00000000
`define QPOT_OFF_DATA       32'h00000004
`define QPOT_OFF_STATUS     32'h00000008
`define QPOT_OFF_RDATA      32'h0000000c
`define QPOT_SCL_HALF       5'h14
`define QPOT_SETTING_RESET  6'h20
`endif

// ===== include/qpot_if.sv
// two-wire link between quad pot master and slave
`default_nettype none
interface qpot_if;
    logic scl_o;
    logic scl_oe;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_s_o;
    logic sda_s_oe;
    logic scl;
    logic sda;
    modport slave  (input scl, input sda, output sda_s_o, output sda_s_oe);
    modport master (input scl, input sda, output scl_o, output scl_oe, output sda_m_o, output sda_m_oe);
endinterface
`default_nettype wire

// ===== include/qpot_pkg.sv
// types shared by both ends of the quad pot serial link
`default_nettype none
package qpot_pkg;
    typedef enum logic [2:0] {
        QPOT_S_IDLE = 3'b000,
        QPOT_S_RX   = 3'b001,
        QPOT_S_ACK  = 3'b010,
        QPOT_S_TX   = 3'b011,
        QPOT_S_TACK = 3'b100,
        QPOT_S_WAIT = 3'b101
    } qpot_slv_state_type;
    typedef enum logic [2:0] {
        QPOT_M_IDLE  = 3'b000,
        QPOT_M_START = 3'b001,
        QPOT_M_BIT   = 3'b010,
        QPOT_M_STOP  = 3'b011,
        QPOT_M_DONE  = 3'b100
    } qpot_mst_state_type;
endpackage
`default_nettype wire
